/* rtl/sprp_regs.vh */
// Purpose : Offsets, field positions and reset values of the speed reference profile bank
// Assumes : Byte addresses are four times the printed register index
// Notes   : Definitions only
`ifndef SPRP_REGS_VH
`define SPRP_REGS_VH
`define SPRP_IDX_LEVELS_FIRST   8'h9a
`define SPRP_IDX_LEVELS_MODE    8'h9c
`define SPRP_IDX_LEVELS_SECOND  8'h9e
`define SPRP_IDX_DUTY_CONFIG    8'ha0
`define SPRP_IDX_DUTY_INPUT     8'ha1
`define SPRP_IDX_STATUS         8'ha2
`define SPRP_RESET_VALUE        32'h00000000
`define SPRP_SECOND_RW_MASK     32'hffff8000
`define SPRP_MODE_RW_MASK       32'hfffffffe
`define SPRP_CFG_RW_MASK        32'h60000006
`define SPRP_OFF1_MSB           30
`define SPRP_OFF1_LSB           23
`define SPRP_CLAMP1_MSB         22
`define SPRP_CLAMP1_LSB         15
`define SPRP_REFA_MSB           14
`define SPRP_REFA_LSB           7
`define SPRP_REFB_HI_MSB        6
`define SPRP_REFB_HI_LSB        0
`define SPRP_REFB_LO_BIT        30
`define SPRP_REFC_MSB           29
`define SPRP_REFC_LSB           22
`define SPRP_REFD_MSB           21
`define SPRP_REFD_LSB           14
`define SPRP_REFE_MSB           13
`define SPRP_REFE_LSB           6
`define SPRP_MIN_DUTY_MSB       5
`define SPRP_MIN_DUTY_LSB       4
`define SPRP_VMODE_MSB          3
`define SPRP_VMODE_LSB          2
`define SPRP_FILTER_BIT         1
`define SPRP_OFF2_MSB           30
`define SPRP_OFF2_LSB           23
`define SPRP_CLAMP2_MSB         22
`define SPRP_CLAMP2_LSB         15
`define SPRP_PTYPE_MSB          30
`define SPRP_PTYPE_LSB          29
`define SPRP_HYST_MSB           2
`define SPRP_HYST_LSB           1
`define SPRP_VMODE_OFF          2'h0
`define SPRP_VMODE_ABOVE        2'h1
`define SPRP_VMODE_BELOW        2'h2
`define SPRP_MIN_CODE0          8'h03
`define SPRP_MIN_CODE1          8'h08
`define SPRP_MIN_CODE2          8'h0d
`define SPRP_MIN_CODE3          8'h1a
`define SPRP_PCT_ONE            8'h03
`define SPRP_FILTER_SHIFT       8
`endif

/* rtl/sprp_duty_filter.v */
// Purpose : First order low pass filter on the measured input duty
// Assumes : One new sample per clock enable cycle
// Notes   : Bypassed when the enable is low so the output follows at once
`timescale 1ns/100ps
module sprp_duty_filter #(
  parameter WIDTH = 8,
  parameter SHIFT = 8
) (
  input  wire             ref_clk_in,
  input  wire             arst_n_in,
  input  wire             ce_in,
  input  wire             enable_in,
  input  wire [WIDTH-1:0] sample_in,
  output wire [WIDTH-1:0] duty_out
);
  reg  [WIDTH+SHIFT-1:0] acc;
  wire [WIDTH+SHIFT-1:0] wide_sample;
  wire [WIDTH+SHIFT-1:0] delta_up;
  wire [WIDTH+SHIFT-1:0] delta_dn;
  wire [WIDTH-1:0]       acc_top;
  wire [WIDTH+SHIFT-1:0] step_up;
  wire [WIDTH+SHIFT-1:0] step_dn;
  wire [WIDTH+SHIFT-1:0] lsb_one;
  assign wide_sample = {sample_in, {SHIFT{1'b0}}};
  assign acc_top     = acc[WIDTH+SHIFT-1:SHIFT];
  // Step of one 256th of the error: a slow tracking filter
  assign delta_up    = (wide_sample - acc) >> SHIFT;
  assign delta_dn    = (acc - wide_sample) >> SHIFT;
  // Never a zero step, or a small error would leave the output short of the sample
  assign lsb_one     = {{(WIDTH+SHIFT-1){1'b0}}, 1'b1};
  assign step_up     = (delta_up == {(WIDTH+SHIFT){1'b0}}) ? lsb_one : delta_up;
  assign step_dn     = (delta_dn == {(WIDTH+SHIFT){1'b0}}) ? lsb_one : delta_dn;
  assign duty_out    = acc_top;
  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      acc <= {(WIDTH+SHIFT){1'b0}};
    end else if (ce_in) begin
      if (!enable_in) begin
        acc <= wide_sample;
      end else if (wide_sample > acc) begin
        acc <= acc + step_up;
      end else if (wide_sample < acc) begin
        acc <= acc - step_dn;
      end
    end
  end
endmodule

/* rtl/sprp_profile_regs.v */
// Purpose : APB register bank for the speed input reference profile and its mode logic
// Assumes : APB slave with zero wait states; pin duty is asynchronous and synchronised here
// Notes   : Byte address is four times each register index
//
// Overview of operation
// - First levels register at index 9Ah, 32 bits, reset zero, all read/write.
// - Bits 30-23 hold turn-off level one, value over 256 of maximum.
// - Bits 22-15 hold clamp level one, value over 256 of maximum.
// - Bits 14-7 hold breakpoint level A, value over 256 of maximum.
// - Breakpoint B upper seven bits sit in bits 6-0 of first register.
// - Breakpoint B lowest bit is bit 30 of mode register.
// - Levels and mode register at index 9Ch, 32 bits, reset zero.
// - Breakpoints C, D, E occupy bits 29-22, 21-14, 13-6.
// - Motor drive starts only once duty exceeds minimum chosen by bits 5-4.
// - Voltage selector zero applies the configured profile over all duties.
// - Selector one enters voltage mode above C plus hysteresis, leaves below.
// - Selector two reverses that; code three is invalid.
// - Filter bit clear passes speed input duty unfiltered.
// - Filter bit set smooths the measured speed input duty.
// - Second levels register 9Eh holds turn-off and clamp two; low bits zero.
// - Two-bit profile type selects equation, linear, staircase or forward-reverse.
// - Hysteresis field codes give zero to three percent of duty.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/100ps
`include "sprp_regs.vh"
module sprp_profile_regs #(
  parameter ADDR_WIDTH = 12
) (
  input  wire                  ref_clk_in,
  input  wire                  arst_n_in,
  input  wire                  ce_in,
  input  wire                  psel_in,
  input  wire                  penable_in,
  input  wire                  pwrite_in,
  input  wire [ADDR_WIDTH-1:0] paddr_in,
  input  wire [31:0]           pwdata_in,
  input  wire [3:0]            pstrb_in,
  output reg  [31:0]           prdata_out,
  output reg                   pready_out,
  output reg                   pslverr_out,
  input  wire [7:0]            duty_pin_in,
  output reg                   drive_enable_out,
  output reg                   voltage_mode_out,
  output reg  [1:0]            profile_type_out,
  output reg  [7:0]            turnoff_level_one_out,
  output reg  [7:0]            clamp_level_one_out,
  output reg  [7:0]            turnoff_level_two_out,
  output reg  [7:0]            clamp_level_two_out,
  output reg  [7:0]            filtered_duty_out
);
  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  reg  [31:0] levels_first;
  reg  [31:0] levels_and_mode;
  reg  [31:0] levels_second;
  reg  [31:0] duty_config;
  reg  [7:0]  duty_sync_a;
  reg  [7:0]  duty_sync_b;
  reg         vmode_active;
  reg  [31:0] next_rdata;
  reg         next_err;
  wire [7:0]  duty_now;
  wire [7:0]  ref_b;
  wire [7:0]  ref_c;
  wire [1:0]  vmode_sel;
  wire [1:0]  min_sel;
  wire [1:0]  switch_hysteresis_field;
  wire [7:0]  switch_hysteresis;
  wire [8:0]  band_high;
  wire [8:0]  band_low;
  reg  [7:0]  min_duty;
  wire        access;
  wire        wr;
  wire [31:0] strb_mask;
  wire [7:0]  word_idx;
  wire        setup;
  wire        wr_commit;
  wire [31:0] wr_bits;
  wire        addr_top_ok;
  wire        hit_first;
  wire        hit_mode;
  wire        hit_second;
  wire        hit_cfg;
  wire        duty_above;
  wire        duty_below;
  reg         next_vmode;
  reg  [31:0] next_levels_first;
  reg  [31:0] next_levels_and_mode;
  reg  [31:0] next_levels_second;
  reg  [31:0] next_duty_config;

  assign access    = psel_in & penable_in;
  assign wr        = access & pwrite_in & ce_in;
  assign word_idx  = paddr_in[9:2];
  assign strb_mask = {{8{pstrb_in[3]}}, {8{pstrb_in[2]}}, {8{pstrb_in[1]}}, {8{pstrb_in[0]}}};
  assign setup     = psel_in & ~penable_in;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Upper address bits must be clear, so no write reaches a register through an alias
  assign addr_top_ok = (paddr_in[ADDR_WIDTH-1:10] == {(ADDR_WIDTH-10){1'b0}});
  assign hit_first   = addr_top_ok & (word_idx == `SPRP_IDX_LEVELS_FIRST);
  assign hit_mode    = addr_top_ok & (word_idx == `SPRP_IDX_LEVELS_MODE);
  assign hit_second  = addr_top_ok & (word_idx == `SPRP_IDX_LEVELS_SECOND);
  assign hit_cfg     = addr_top_ok & (word_idx == `SPRP_IDX_DUTY_CONFIG);
  // Commit only in the answered access cycle, and never when the access is refused
  assign wr_commit   = wr & pready_out & ~pslverr_out;
  assign wr_bits     = pwdata_in & strb_mask;

  // ----------------------------------------------------------------
  // Field views
  // ----------------------------------------------------------------
  assign ref_b = {levels_first[`SPRP_REFB_HI_MSB:`SPRP_REFB_HI_LSB],
                  levels_and_mode[`SPRP_REFB_LO_BIT]};
  assign ref_c     = levels_and_mode[`SPRP_REFC_MSB:`SPRP_REFC_LSB];
  assign min_sel   = levels_and_mode[`SPRP_MIN_DUTY_MSB:`SPRP_MIN_DUTY_LSB];
  assign vmode_sel = levels_and_mode[`SPRP_VMODE_MSB:`SPRP_VMODE_LSB];
  assign switch_hysteresis_field = duty_config[`SPRP_HYST_MSB:`SPRP_HYST_LSB];
  // Percent steps of about 3/256 each; full 8-bit scale is 100 percent
  assign switch_hysteresis = `SPRP_PCT_ONE * {6'h00, switch_hysteresis_field};
  assign band_high = {1'b0, ref_c} + {1'b0, switch_hysteresis};
  assign band_low  = {1'b0, ref_c} - {1'b0, switch_hysteresis};
  // An underflowed low edge never switches back
  assign duty_above = ({1'b0, duty_now} > band_high);
  assign duty_below = ({1'b0, duty_now} < band_low) & ~band_low[8];

  always @* begin
    case (min_sel)
      2'h0:    min_duty = `SPRP_MIN_CODE0;
      2'h1:    min_duty = `SPRP_MIN_CODE1;
      2'h2:    min_duty = `SPRP_MIN_CODE2;
      default: min_duty = `SPRP_MIN_CODE3;
    endcase
  end

  // ----------------------------------------------------------------
  // Voltage mode selection
  // ----------------------------------------------------------------
  // Inside the band neither compare is true, so the last mode holds
  always @* begin
    next_vmode = vmode_active;
    case (vmode_sel)
      `SPRP_VMODE_ABOVE: begin
        if (duty_above) begin
          next_vmode = 1'b1;
        end else if (duty_below) begin
          next_vmode = 1'b0;
        end
      end
      `SPRP_VMODE_BELOW: begin
        if (duty_above) begin
          next_vmode = 1'b0;
        end else if (duty_below) begin
          next_vmode = 1'b1;
        end
      end
      default: begin
        // Invalid code three behaves as code zero
        next_vmode = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Speed pin filter
  // ----------------------------------------------------------------
  sprp_duty_filter #(
    .WIDTH (8),
    .SHIFT (`SPRP_FILTER_SHIFT)
  ) u_filter (
    .ref_clk_in (ref_clk_in),
    .arst_n_in  (arst_n_in),
    .ce_in      (ce_in),
    .enable_in  (levels_and_mode[`SPRP_FILTER_BIT]),
    .sample_in  (duty_sync_b),
    .duty_out   (duty_now)
  );

  // ----------------------------------------------------------------
  // Read mux and decode
  // ----------------------------------------------------------------
  always @* begin
    next_rdata = 32'h00000000;
    next_err   = 1'b0;
    if (word_idx == `SPRP_IDX_LEVELS_FIRST) begin
      next_rdata = levels_first;
    end else if (word_idx == `SPRP_IDX_LEVELS_MODE) begin
      next_rdata = levels_and_mode;
    end else if (word_idx == `SPRP_IDX_LEVELS_SECOND) begin
      next_rdata = levels_second;
    end else if (word_idx == `SPRP_IDX_DUTY_CONFIG) begin
      next_rdata = duty_config;
    end else if (word_idx == `SPRP_IDX_DUTY_INPUT) begin
      next_rdata = {24'h000000, duty_now};
    end else if (word_idx == `SPRP_IDX_STATUS) begin
      next_rdata = {30'h0, vmode_active, drive_enable_out};
    end else begin
      next_err = 1'b1;
    end
    if (paddr_in[ADDR_WIDTH-1:10] != 0) begin
      next_err   = 1'b1;
      next_rdata = 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // Register writes and bus answer
  // ----------------------------------------------------------------
  // Read-only bits keep their stored value whatever the byte lanes carry
  always @* begin
    next_levels_first    = levels_first;
    next_levels_and_mode = levels_and_mode;
    next_levels_second   = levels_second;
    next_duty_config     = duty_config;
    if (wr_commit) begin
      if (hit_first) begin
        next_levels_first = (levels_first & ~strb_mask) | wr_bits;
      end else if (hit_mode) begin
        next_levels_and_mode = (levels_and_mode & ~(strb_mask & `SPRP_MODE_RW_MASK))
                             | (wr_bits & `SPRP_MODE_RW_MASK);
      end else if (hit_second) begin
        next_levels_second = (levels_second & ~(strb_mask & `SPRP_SECOND_RW_MASK))
                           | (wr_bits & `SPRP_SECOND_RW_MASK);
      end else if (hit_cfg) begin
        next_duty_config = (duty_config & ~(strb_mask & `SPRP_CFG_RW_MASK))
                         | (wr_bits & `SPRP_CFG_RW_MASK);
      end
    end
  end

  // Answer one cycle after setup: zero wait states, data and error registered
  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      levels_first    <= `SPRP_RESET_VALUE;
      levels_and_mode <= `SPRP_RESET_VALUE;
      levels_second   <= `SPRP_RESET_VALUE;
      duty_config     <= `SPRP_RESET_VALUE;
      prdata_out      <= 32'h00000000;
      pready_out      <= 1'b0;
      pslverr_out     <= 1'b0;
    end else if (ce_in) begin
      pready_out      <= setup;
      pslverr_out     <= setup & next_err;
      prdata_out      <= (setup & ~pwrite_in) ? next_rdata : 32'h00000000;
      levels_first    <= next_levels_first;
      levels_and_mode <= next_levels_and_mode;
      levels_second   <= next_levels_second;
      duty_config     <= next_duty_config;
    end
  end

  // ----------------------------------------------------------------
  // Duty input synchroniser and mode selection
  // ----------------------------------------------------------------
  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      duty_sync_a      <= 8'h00;
      duty_sync_b      <= 8'h00;
      vmode_active     <= 1'b0;
      drive_enable_out <= 1'b0;
      voltage_mode_out <= 1'b0;
    end else if (ce_in) begin
      // Bus width pin value may skew between bits; sampled twice only
      duty_sync_a <= duty_pin_in;
      duty_sync_b <= duty_sync_a;
      drive_enable_out <= (duty_now > min_duty);
      vmode_active     <= next_vmode;
      voltage_mode_out <= vmode_active;
    end
  end

  // ----------------------------------------------------------------
  // Level outputs to the reference generator
  // ----------------------------------------------------------------
  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      profile_type_out      <= 2'h0;
      turnoff_level_one_out <= 8'h00;
      clamp_level_one_out   <= 8'h00;
      turnoff_level_two_out <= 8'h00;
      clamp_level_two_out   <= 8'h00;
      filtered_duty_out     <= 8'h00;
    end else if (ce_in) begin
      profile_type_out      <= duty_config[`SPRP_PTYPE_MSB:`SPRP_PTYPE_LSB];
      turnoff_level_one_out <= levels_first[`SPRP_OFF1_MSB:`SPRP_OFF1_LSB];
      clamp_level_one_out   <= levels_first[`SPRP_CLAMP1_MSB:`SPRP_CLAMP1_LSB];
      turnoff_level_two_out <= levels_second[`SPRP_OFF2_MSB:`SPRP_OFF2_LSB];
      clamp_level_two_out   <= levels_second[`SPRP_CLAMP2_MSB:`SPRP_CLAMP2_LSB];
      filtered_duty_out     <= duty_now;
    end
  end

  // Breakpoints A, B, D, E drive no output; they are only stored and read back by software
  wire [7:0] unused_ref_a = levels_first[`SPRP_REFA_MSB:`SPRP_REFA_LSB];
  wire [7:0] unused_ref_d = levels_and_mode[`SPRP_REFD_MSB:`SPRP_REFD_LSB] ^ ref_b
                          ^ levels_and_mode[`SPRP_REFE_MSB:`SPRP_REFE_LSB];
endmodule

/* bench/sprp_profile_regs_sva.sv */
// Purpose : Concurrent checks on the profile register bank ports
// Assumes : Zero wait APB slave; clock enable drops only while the bus is idle
// Notes   : Bound to the design top after the module
`timescale 1ns/100ps
module sprp_profile_regs_sva #(
  parameter ADDR_WIDTH = 12
) (
  input wire logic                  ref_clk_in,
  input wire logic                  arst_n_in,
  input wire logic                  ce_in,
  input wire logic                  psel_in,
  input wire logic                  penable_in,
  input wire logic                  pwrite_in,
  input wire logic [ADDR_WIDTH-1:0] paddr_in,
  input wire logic [31:0]           pwdata_in,
  input wire logic [3:0]            pstrb_in,
  input wire logic [31:0]           prdata_out,
  input wire logic                  pready_out,
  input wire logic                  pslverr_out,
  input wire logic [7:0]            duty_pin_in,
  input wire logic                  drive_enable_out,
  input wire logic                  voltage_mode_out,
  input wire logic [1:0]            profile_type_out,
  input wire logic [7:0]            turnoff_level_one_out,
  input wire logic [7:0]            clamp_level_one_out,
  input wire logic [7:0]            turnoff_level_two_out,
  input wire logic [7:0]            clamp_level_two_out,
  input wire logic [7:0]            filtered_duty_out
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  wire apb_done  = psel_in && penable_in && pready_out;
  wire mapped    = (paddr_in == 12'h268) || (paddr_in == 12'h270) || (paddr_in == 12'h278) ||
                   (paddr_in == 12'h280) || (paddr_in == 12'h284) || (paddr_in == 12'h288);
  wire wr_first  = apb_done && pwrite_in && (paddr_in == 12'h268);
  wire wr_second = apb_done && pwrite_in && (paddr_in == 12'h278);

  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  chk_ready_after_setup:
    assert property (psel_in && !penable_in && ce_in |=> pready_out)
    else $error("no ready one cycle after setup");
  chk_ready_single:
    assert property (pready_out |=> !pready_out)
    else $error("ready stood longer than one cycle");
  chk_err_unmapped:
    assert property (apb_done && !mapped |-> pslverr_out && prdata_out == 32'h0)
    else $error("unmapped access not refused");
  chk_err_mapped:
    assert property (apb_done && mapped |-> !pslverr_out)
    else $error("mapped access refused");
  chk_mode_low_zero:
    assert property (apb_done && !pwrite_in && paddr_in == 12'h270 |-> prdata_out[0] == 1'b0)
    else $error("reserved mode bit read as one");
  chk_second_low_zero:
    assert property (apb_done && !pwrite_in && paddr_in == 12'h278 |-> prdata_out[14:0] == 15'h0)
    else $error("reserved second bits read nonzero");
  // Level outputs may lag the register by one cycle, so two write slots count
  chk_off1_source:
    assert property ($changed(turnoff_level_one_out) |-> $past(wr_first) || $past(wr_first, 2))
    else $error("turn-off level one changed without a write");
  chk_clamp2_source:
    assert property ($changed(clamp_level_two_out) |-> $past(wr_second) || $past(wr_second, 2))
    else $error("clamp level two changed without a write");
  chk_drive_below_min:
    assert property ((filtered_duty_out <= 8'h03) [*2] |-> !drive_enable_out)
    else $error("drive enabled below every minimum");
  chk_drive_above_max:
    assert property ((filtered_duty_out > 8'h1a) [*2] |-> drive_enable_out)
    else $error("drive off above every minimum");

  cover property (wr_first);
  cover property (apb_done && pslverr_out);
  cover property ($rose(voltage_mode_out));
endmodule

bind sprp_profile_regs sprp_profile_regs_sva #(.ADDR_WIDTH(ADDR_WIDTH)) u_sprp_sva (
  .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .ce_in(ce_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .pstrb_in(pstrb_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .duty_pin_in(duty_pin_in), .drive_enable_out(drive_enable_out),
  .voltage_mode_out(voltage_mode_out), .profile_type_out(profile_type_out),
  .turnoff_level_one_out(turnoff_level_one_out), .clamp_level_one_out(clamp_level_one_out),
  .turnoff_level_two_out(turnoff_level_two_out), .clamp_level_two_out(clamp_level_two_out),
  .filtered_duty_out(filtered_duty_out));

/* bench/sprp_profile_regs_tb_top.sv */
// Purpose : Self-checking bench for the profile register bank
// Assumes : Unfiltered duty path settles within eight cycles of a pin change
// Notes   : Clock enable dropped once near the end; one idle cycle between transfers
`timescale 1ns/100ps
module sprp_profile_regs_tb_top;
  localparam logic [11:0] A1 = 12'h268;
  localparam logic [11:0] A2 = 12'h270;
  localparam logic [11:0] A3 = 12'h278;
  localparam logic [11:0] AC = 12'h280;
  localparam logic [31:0] V1 = 32'h5555aaaa;
  localparam logic [31:0] V2 = 32'ha5c3ffff;
  localparam logic [7:0]  MIN_TH [4] = '{8'h03, 8'h08, 8'h0d, 8'h1a};
  logic        ref_clk_in  = 1'b0;
  logic        arst_n_in   = 1'b0;
  logic        ce_in       = 1'b1;
  logic        psel_in     = 1'b0;
  logic        penable_in  = 1'b0;
  logic        pwrite_in   = 1'b0;
  logic [11:0] paddr_in    = 12'h000;
  logic [31:0] pwdata_in   = 32'h00000000;
  logic [3:0]  pstrb_in    = 4'h0;
  logic [7:0]  duty_pin_in = 8'h00;
  logic [31:0] prdata_out;
  logic        pready_out, pslverr_out, drive_enable_out, voltage_mode_out;
  logic [1:0]  profile_type_out;
  logic [7:0]  off1, clamp1, off2, clamp2, filtered_duty_out;
  logic [31:0] rd;
  logic        er;
  int          err_total = 0;
  int          n_checks  = 0;
  int          cycles    = 0;
  int          i;

  sprp_profile_regs DUT (
    .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .ce_in(ce_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .duty_pin_in(duty_pin_in),
    .drive_enable_out(drive_enable_out), .voltage_mode_out(voltage_mode_out),
    .profile_type_out(profile_type_out), .turnoff_level_one_out(off1),
    .clamp_level_one_out(clamp1), .turnoff_level_two_out(off2),
    .clamp_level_two_out(clamp2), .filtered_duty_out(filtered_duty_out));

  // ----------------------------------------
  // Clock, timeout and verdict
  // ----------------------------------------
  always #5 ref_clk_in = ~ref_clk_in;

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Run needs well under a thousand cycles; the ceiling leaves ample margin
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      tally_and_finish();
    end
  end

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge ref_clk_in);
    psel_in    <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in  <= w;
    paddr_in   <= a;
    pwdata_in  <= d;
    pstrb_in   <= s;
    @(posedge ref_clk_in);
    penable_in <= 1'b1;
    do @(posedge ref_clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(rd, exp, what);
  endtask

  // Selector, breakpoint C and minimum code; filter and reserved bit 0 left clear
  task automatic mode(input logic [7:0] c, input logic [1:0] sel, input logic [1:0] mind);
    wr(A2, {2'b00, c, 16'h0000, mind, sel, 2'b00});
  endtask

  task automatic run(input logic [7:0] d, input logic e);
    duty_pin_in <= d;
    repeat (8) @(posedge ref_clk_in);
    chk({31'h0, voltage_mode_out}, {31'h0, e}, "voltage mode");
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge ref_clk_in);
    arst_n_in <= 1'b1;
    rdchk(A1, 32'h0, "first reset");
    rdchk(A2, 32'h0, "mode reset");
    rdchk(A3, 32'h0, "second reset");
    wr(A1, V1);
    rdchk(A1, V1, "first readback");
    chk({24'h0, off1}, {24'h0, V1[30:23]}, "off1");
    chk({24'h0, clamp1}, {24'h0, V1[22:15]}, "clamp1");
    wr(A1, 32'hffffffff);
    rdchk(A1, 32'hffffffff, "first ones");
    wr(A2, 32'hffffffff);
    rdchk(A2, 32'hfffffffe, "mode ones");
    wr(A3, V2);
    rdchk(A3, V2 & 32'hffff8000, "second readback");
    chk({off2, clamp2}, {V2[30:23], V2[22:15]}, "second levels");
    apb(1'b1, A3, 32'h0, 4'b0001);
    rdchk(A3, V2 & 32'hffff8000, "reserved lane");
    apb(1'b1, A3, 32'h0, 4'b1000);
    rdchk(A3, V2 & 32'h00ff8000, "top lane");
    apb(1'b0, 12'h26c, 32'h0, 4'h0);
    chk({er, rd[30:0]}, 32'h80000000, "gap refused");
    apb(1'b1, 12'h668, 32'h0, 4'hf);
    chk({31'h0, er}, 32'h1, "high address refused");
    rdchk(A1, 32'hffffffff, "no alias write");
    wr(AC, 32'hffffffff);
    rdchk(AC, 32'h60000006, "duty config");
    chk({30'h0, profile_type_out}, 32'h3, "profile type");
    for (i = 0; i < 4; i++) begin
      mode(8'h00, 2'h0, i[1:0]);
      duty_pin_in <= MIN_TH[i];
      repeat (8) @(posedge ref_clk_in);
      chk({31'h0, drive_enable_out}, 32'h0, "at minimum");
      duty_pin_in <= MIN_TH[i] + 8'h01;
      repeat (8) @(posedge ref_clk_in);
      chk({31'h0, drive_enable_out}, 32'h1, "above minimum");
    end
    wr(AC, 32'h00000002);
    mode(8'h80, 2'h1, 2'h0);
    run(8'h7c, 1'b0);
    run(8'h84, 1'b1);
    run(8'h80, 1'b1);
    run(8'h7c, 1'b0);
    run(8'h80, 1'b0);
    mode(8'h80, 2'h2, 2'h0);
    run(8'h84, 1'b0);
    run(8'h7c, 1'b1);
    run(8'h80, 1'b1);
    mode(8'h80, 2'h0, 2'h0);
    run(8'h7c, 1'b0);
    run(8'h84, 1'b0);
    mode(8'h80, 2'h3, 2'h0);
    run(8'h7c, 1'b0);
    wr(AC, 32'h00000006);
    mode(8'h80, 2'h1, 2'h0);
    run(8'h84, 1'b0);
    run(8'h8a, 1'b1);
    wr(AC, 32'h00000004);
    run(8'h7b, 1'b1);
    run(8'h79, 1'b0);
    run(8'h00, 1'b0);
    chk({24'h0, filtered_duty_out}, 32'h0, "unfiltered low");
    wr(A2, 32'h00000002);
    run(8'hc8, 1'b0);
    chk({31'h0, (filtered_duty_out - 8'h01) < 8'hc7}, 32'h1, "filter slews");
    wr(A2, 32'h00000000);
    run(8'hc8, 1'b0);
    chk({24'h0, filtered_duty_out}, 32'hc8, "unfiltered high");
    rdchk(12'h288, 32'h00000001, "status word");
    rdchk(12'h284, 32'h000000c8, "duty readback");
    ce_in       <= 1'b0;
    duty_pin_in <= 8'h10;
    repeat (8) @(posedge ref_clk_in);
    chk({24'h0, filtered_duty_out}, 32'hc8, "frozen by enable");
    ce_in       <= 1'b1;
    run(8'h10, 1'b0);
    chk({24'h0, filtered_duty_out}, 32'h10, "resumes after enable");
    tally_and_finish();
  end
endmodule
